//--- msc_defines.svh
/*
  holds the offsets, field positions, masks and reset values of the
  machine state control block.
  assumes inclusion by bare name from every file that needs a number.
*/
// Overview of operation
// - bit 13 requests reduced power mode
// - exception copies trap byte order into byte order
// - bit 16 gates external and decrementer interrupts
// - bit 17 restricts execution to user instructions
// - bit 18 clear blocks floating-point dispatch
// - machine check: gate clear checkstops, set traps
// - bit 21 traces each cleanly completed instruction not marked no_trace
// - bit 22 traces each successful branch
// - bit 25 picks vector prefix 0x000 or 0xFFF
// - bit 26 enables instruction address translation
// - bit 27 enables data address translation
// - bit 29 marks process for performance monitor
// - bit 30 flags exception as recoverable
// - bit 31 selects little endian when set
// - save full reserved bits, drop partial ones
// - both trap mode bits zero: no fp traps
// - any trap mode bit set: precise mode
// - saved copy valid at first handler instruction
// - any exception clears the interrupt gate
// - exception saves then clears recoverable flag
// - exception clears both translation enables
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSC_OFS_STATE 8'h00
`define MSC_OFS_SAVED 8'h04
`define MSC_OFS_STATUS 8'h08

// ----------------------------------------------------------------
// field positions, msb-first numbering turned into vector index
// ----------------------------------------------------------------
`define MSC_B(n) (31 - (n))
`define MSC_POW `MSC_B(13)
`define MSC_ILE `MSC_B(15)
`define MSC_EE `MSC_B(16)
`define MSC_PR `MSC_B(17)
`define MSC_FP `MSC_B(18)
`define MSC_ME `MSC_B(19)
`define MSC_FE0 `MSC_B(20)
`define MSC_SE `MSC_B(21)
`define MSC_BE `MSC_B(22)
`define MSC_FE1 `MSC_B(23)
`define MSC_IP `MSC_B(25)
`define MSC_IR `MSC_B(26)
`define MSC_DR `MSC_B(27)
`define MSC_PM `MSC_B(29)
`define MSC_RI `MSC_B(30)
`define MSC_LE `MSC_B(31)

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define MSC_SAVE_MASK 32'h87C0FFFF
`define MSC_WR_MASK 32'h87C5FF7F
`define MSC_STATE_RST 32'h00000040
`define MSC_PREFIX_LO 12'h000
`define MSC_PREFIX_HI 12'hFFF

`endif

//--- msc_pkg.sv
/*
  holds the carrier types of the machine state control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package msc_pkg;

  // exception entry request from the sequencer
  typedef struct packed {
    logic [19:0] offset;
    logic [9:0] status;
  } msc_exc_req_t;

  // completion report of one instruction
  typedef struct packed {
    logic is_branch;
    logic no_trace;
    logic faulted;
  } msc_instr_t;

endpackage

//--- msc_event_gate.sv
/*
  holds the gating of asynchronous, machine-check and floating-point
  events by the state word fields.
  assumes all event inputs come from logic on i_clk.
*/
`timescale 1ns/10ps
module msc_event_gate (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // state word fields
  input wire logic i_ee,
  input wire logic i_me,
  input wire logic i_fp,
  input wire logic i_fe_any,
  input wire logic i_user_only,
  // events
  input wire logic i_ext_req,
  input wire logic i_dec_req,
  input wire logic i_mchk,
  input wire logic i_fp_instr,
  input wire logic i_fp_exc,
  input wire logic i_priv_instr,
  // gated results
  output logic o_ext_take,
  output logic o_dec_take,
  output logic o_mchk_take,
  output logic o_checkstop,
  output logic o_fp_unavail,
  output logic o_fp_prog,
  output logic o_priv_fault
);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_take <= 1'b0;
      o_dec_take <= 1'b0;
    end else begin
      o_ext_take <= i_ext_req & i_ee;
      o_dec_take <= i_dec_req & i_ee;
    end
  end

  // checkstop is sticky: only reset leaves it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mchk_take <= 1'b0;
      o_checkstop <= 1'b0;
    end else begin
      o_mchk_take <= i_mchk & i_me & ~o_checkstop;
      if (i_mchk && !i_me) begin
        o_checkstop <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fp_unavail <= 1'b0;
      o_fp_prog <= 1'b0;
      o_priv_fault <= 1'b0;
    end else begin
      o_fp_unavail <= i_fp_instr & ~i_fp;
      o_fp_prog <= i_fp_exc & i_fp & i_fe_any;
      o_priv_fault <= i_priv_instr & i_user_only;
    end
  end

  ext_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ext_req && !i_ee) |=> !o_ext_take)
    else $error("external interrupt taken while gate clear");
  mchk_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_mchk && !i_me) |=> o_checkstop && !o_mchk_take)
    else $error("machine check with gate clear did not checkstop");
  fp_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_fp_exc && !i_fe_any) |=> !o_fp_prog)
    else $error("floating-point trap taken with trap modes off");

endmodule

//--- msc_trace_gen.sv
/*
  holds the single-step and branch trace decision for each completed
  instruction.
  assumes one completion report per cycle at most, on i_clk.
*/
`timescale 1ns/10ps
module msc_trace_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // trace enables
  input wire logic i_se,
  input wire logic i_be,
  // completion report
  input wire logic i_done,
  input wire msc_pkg::msc_instr_t i_instr,
  // trace request
  output logic o_trace,
  output logic o_trace_branch
);

  logic clean;
  logic step_hit;
  logic branch_hit;

  assign clean = i_done & ~i_instr.faulted;
  assign step_hit = clean & i_se & ~i_instr.no_trace;
  assign branch_hit = clean & i_be & i_instr.is_branch;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trace <= 1'b0;
      o_trace_branch <= 1'b0;
    end else begin
      o_trace <= step_hit | branch_hit;
      o_trace_branch <= branch_hit & ~step_hit;
    end
  end

  step_excl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_done && i_instr.no_trace && !(i_be && i_instr.is_branch))
    |=> !o_trace)
    else $error("trace raised on excluded instruction");
  branch_tr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_done && !i_instr.faulted && i_be && i_instr.is_branch) |=> o_trace)
    else $error("successful branch not traced");

endmodule

//--- msc_top.sv
/*
  holds the machine state word, its saved copy, exception entry and
  return, field decode onto control outputs, and the register port.
  assumes an exception sequencer and the core pipeline on i_clk,
  and a master on the plain register port that never stalls.
*/
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "msc_defines.svh"
module msc_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [31:0] o_rdata,
  // exception entry and return
  input wire logic i_exc_take,
  input wire msc_pkg::msc_exc_req_t i_exc_req,
  input wire logic i_rfi,
  output logic o_vector_valid,
  output logic [31:0] o_vector_addr,
  // core events
  input wire logic i_ext_req,
  input wire logic i_dec_req,
  input wire logic i_mchk,
  input wire logic i_fp_instr,
  input wire logic i_fp_exc,
  input wire logic i_priv_instr,
  input wire logic i_done,
  input wire msc_pkg::msc_instr_t i_instr,
  // gated event requests
  output logic o_ext_take,
  output logic o_dec_take,
  output logic o_mchk_take,
  output logic o_checkstop,
  output logic o_fp_unavail,
  output logic o_fp_prog,
  output logic o_priv_fault,
  output logic o_trace,
  output logic o_trace_branch,
  // decoded state word fields
  output logic [31:0] o_state,
  output logic [31:0] o_saved,
  output logic o_low_power_req,
  output logic o_user_only,
  output logic o_fp_dispatch_ok,
  output logic o_fp_exc_enable,
  output logic o_fp_precise,
  output logic o_fetch_xlate,
  output logic o_data_xlate,
  output logic o_perf_mark,
  output logic o_recoverable,
  output logic o_little_endian
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] state_reg;
  logic [31:0] state_next;
  logic [31:0] saved_reg;
  logic [31:0] saved_next;
  logic [31:0] exc_info;
  logic [7:0] entry_cnt_reg;
  logic fe_any;
  logic sel_state;
  logic sel_saved;
  logic sel_status;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign sel_state = (i_addr == `MSC_OFS_STATE);
  assign sel_saved = (i_addr == `MSC_OFS_SAVED);
  assign sel_status = (i_addr == `MSC_OFS_STATUS);

  // exception-specific info lands in 1:4 and 10:15
  assign exc_info = {1'b0, i_exc_req.status[9:6], 5'h00,
                     i_exc_req.status[5:0], 16'h0000};

  // ----------------------------------------------------------------
  // next state word
  // ----------------------------------------------------------------
  // priority: entry over return over software write, so an
  // exception is never masked by a concurrent write
  always_comb begin
    state_next = state_reg;
    if (i_exc_take) begin
      state_next[`MSC_POW] = 1'b0;
      state_next[`MSC_EE] = 1'b0;
      state_next[`MSC_PR] = 1'b0;
      state_next[`MSC_FP] = 1'b0;
      state_next[`MSC_FE0] = 1'b0;
      state_next[`MSC_SE] = 1'b0;
      state_next[`MSC_BE] = 1'b0;
      state_next[`MSC_FE1] = 1'b0;
      state_next[`MSC_IR] = 1'b0;
      state_next[`MSC_DR] = 1'b0;
      state_next[`MSC_PM] = 1'b0;
      state_next[`MSC_RI] = 1'b0;
      state_next[`MSC_LE] = state_reg[`MSC_ILE];
    end else if (i_rfi) begin
      state_next = (saved_reg & `MSC_SAVE_MASK & `MSC_WR_MASK) |
                   (state_reg & ~(`MSC_SAVE_MASK & `MSC_WR_MASK));
    end else if (i_wr_stb && sel_state) begin
      state_next = (i_wdata & `MSC_WR_MASK) | (state_reg & ~`MSC_WR_MASK);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= `MSC_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // saved copy
  // ----------------------------------------------------------------
  always_comb begin
    saved_next = saved_reg;
    if (i_exc_take) begin
      saved_next = (state_reg & `MSC_SAVE_MASK) | exc_info;
    end else if (i_wr_stb && sel_saved) begin
      saved_next = i_wdata;
    end
  end

  // written on the entry edge, the same edge that raises the vector valid
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      saved_reg <= 32'h00000000;
    end else begin
      saved_reg <= saved_next;
    end
  end

  // ----------------------------------------------------------------
  // handler vector
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vector_valid <= 1'b0;
      o_vector_addr <= 32'h00000000;
    end else begin
      o_vector_valid <= i_exc_take;
      if (i_exc_take) begin
        o_vector_addr <= {state_reg[`MSC_IP] ? `MSC_PREFIX_HI : `MSC_PREFIX_LO,
                          i_exc_req.offset};
      end
    end
  end

  // entry counter only for software visibility, wraps silently
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      entry_cnt_reg <= 8'h00;
    end else if (i_exc_take) begin
      entry_cnt_reg <= entry_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  assign status_word = {16'h0000, entry_cnt_reg, 4'h0, o_fp_precise,
                        o_fp_exc_enable, o_low_power_req, o_checkstop};

  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_state) begin
      rd_mux = state_reg;
    end else if (sel_saved) begin
      rd_mux = saved_reg;
    end else if (sel_status) begin
      rd_mux = status_word;
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= i_rd_stb ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // field decode, straight from the state flops
  // ----------------------------------------------------------------
  assign fe_any = state_reg[`MSC_FE0] | state_reg[`MSC_FE1];
  assign o_state = state_reg;
  assign o_saved = saved_reg;
  assign o_low_power_req = state_reg[`MSC_POW];
  assign o_user_only = state_reg[`MSC_PR];
  assign o_fp_dispatch_ok = state_reg[`MSC_FP];
  assign o_fp_exc_enable = fe_any;
  // both imprecise settings still run precise
  assign o_fp_precise = fe_any;
  assign o_fetch_xlate = state_reg[`MSC_IR];
  assign o_data_xlate = state_reg[`MSC_DR];
  assign o_perf_mark = state_reg[`MSC_PM];
  assign o_recoverable = state_reg[`MSC_RI];
  assign o_little_endian = state_reg[`MSC_LE];

  // ----------------------------------------------------------------
  // event gating and trace
  // ----------------------------------------------------------------
  msc_event_gate u_gate (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ee(state_reg[`MSC_EE]),
    .i_me(state_reg[`MSC_ME]),
    .i_fp(state_reg[`MSC_FP]),
    .i_fe_any(fe_any),
    .i_user_only(state_reg[`MSC_PR]),
    .i_ext_req(i_ext_req),
    .i_dec_req(i_dec_req),
    .i_mchk(i_mchk),
    .i_fp_instr(i_fp_instr),
    .i_fp_exc(i_fp_exc),
    .i_priv_instr(i_priv_instr),
    .o_ext_take(o_ext_take),
    .o_dec_take(o_dec_take),
    .o_mchk_take(o_mchk_take),
    .o_checkstop(o_checkstop),
    .o_fp_unavail(o_fp_unavail),
    .o_fp_prog(o_fp_prog),
    .o_priv_fault(o_priv_fault)
  );

  msc_trace_gen u_trace (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_se(state_reg[`MSC_SE]),
    .i_be(state_reg[`MSC_BE]),
    .i_done(i_done),
    .i_instr(i_instr),
    .o_trace(o_trace),
    .o_trace_branch(o_trace_branch)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  entry_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_exc_take |=> !o_state[`MSC_EE] && !o_fetch_xlate && !o_data_xlate)
    else $error("entry left gate or translation enabled");
  entry_endian_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_exc_take |=> o_little_endian == $past(o_state[`MSC_ILE]))
    else $error("byte order not taken from trap byte order");
  save_ri_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_exc_take |=> o_saved[`MSC_RI] == $past(o_recoverable) && !o_recoverable)
    else $error("recoverable flag not saved and cleared");
  save_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_exc_take |=> (o_saved & 32'h87C0FFFF) == ($past(o_state) & 32'h87C0FFFF))
    else $error("saved copy differs in copied positions");
  partial_bits_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_exc_take && i_exc_req.status == 10'h000) |=>
    o_saved[30:27] == 4'h0 && o_saved[21:19] == 3'h0)
    else $error("partial reserved bits leaked into saved copy");
  vector_base_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_exc_take |=> o_vector_valid &&
    o_vector_addr[31:20] == ($past(o_state[`MSC_IP]) ? 12'hFFF : 12'h000))
    else $error("vector prefix wrong");
  saved_ready_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_vector_valid |-> o_saved[`MSC_ME] == o_state[`MSC_ME])
    else $error("saved copy not ready at handler start");
  fp_precise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_state[`MSC_FE0] ^ o_state[`MSC_FE1]) |-> o_fp_precise)
    else $error("imprecise setting not run precise");
  rd_timing_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_rd_stb |=> o_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  sw_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr_stb && sel_state && !i_exc_take && !i_rfi) |=>
    o_low_power_req == $past(i_wdata[`MSC_POW]))
    else $error("state word write lost");
  ep_check_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_fp_instr && !o_fp_dispatch_ok) |=> o_fp_unavail)
    else $error("floating-point dispatch not blocked");

  entry_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_exc_take ##1 o_vector_valid ##[1:20] i_rfi);
  stop_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_checkstop));
  trace_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_trace_branch);
  high_vec_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_vector_valid && o_vector_addr[31:20] == 12'hFFF);

endmodule

//--- testbench.sv
/*
  holds the self-checking bench of the machine state control block:
  register port tasks, event pulses, trace reports and exception entry.
  assumes msc_pkg compiled first and msc_top as the device under test.
*/
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic exc_take = 1'b0;
  logic rfi = 1'b0;
  logic done = 1'b0;
  logic [5:0] ev = 6'h00;
  msc_pkg::msc_exc_req_t exc_req = '0;
  msc_pkg::msc_instr_t instr = '0;
  logic [31:0] rdata, vec_addr, state, saved;
  logic vec_valid, ext_take, dec_take, mchk_take, checkstop, fp_unavail, fp_prog;
  logic priv_fault, trace, trace_br, low_pwr, user_only, fp_ok, fp_en, fp_prec;
  logic fetch_x, data_x, perf, recov, little;
  logic [31:0] st, sv;
  int miscompares = 0;
  int n_compared = 0;

  msc_top u_msc_top (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rdata(rdata),
    .i_exc_take(exc_take), .i_exc_req(exc_req), .i_rfi(rfi),
    .o_vector_valid(vec_valid), .o_vector_addr(vec_addr),
    .i_ext_req(ev[0]), .i_dec_req(ev[1]), .i_mchk(ev[2]), .i_fp_instr(ev[3]),
    .i_fp_exc(ev[4]), .i_priv_instr(ev[5]), .i_done(done), .i_instr(instr),
    .o_ext_take(ext_take), .o_dec_take(dec_take), .o_mchk_take(mchk_take),
    .o_checkstop(checkstop), .o_fp_unavail(fp_unavail), .o_fp_prog(fp_prog),
    .o_priv_fault(priv_fault), .o_trace(trace), .o_trace_branch(trace_br),
    .o_state(state), .o_saved(saved), .o_low_power_req(low_pwr), .o_user_only(user_only),
    .o_fp_dispatch_ok(fp_ok), .o_fp_exc_enable(fp_en), .o_fp_precise(fp_prec),
    .o_fetch_xlate(fetch_x), .o_data_xlate(data_x), .o_perf_mark(perf),
    .o_recoverable(recov), .o_little_endian(little)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // writes land on the edge that takes the strobe; non-writable bits stay 0
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    if (a == 8'h00)
      st = d & 32'h87C5FF7F;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask

  // one-cycle event pulse; the gated answer stands in the next cycle
  task automatic fire(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    #1;
  endtask

  task automatic tr(input msc_pkg::msc_instr_t i, input logic et, input logic eb);
    @(posedge clk);
    done <= 1'b1;
    instr <= i;
    @(posedge clk);
    done <= 1'b0;
    #1 chk("trace", {31'h0, trace}, {31'h0, et});
    chk("trace_branch", {31'h0, trace_br}, {31'h0, eb});
  endtask

  // expected entry: save masked word plus status, clear the listed fields
  task automatic exc(input logic [19:0] off, input logic [9:0] s);
    logic [31:0] ns;
    sv = (st & 32'h87C0FFFF) | {1'b0, s[9:6], 5'h00, s[5:0], 16'h0000};
    ns = (st & ~32'h0004EF37) | {31'h0, st[16]};
    @(posedge clk);
    exc_take <= 1'b1;
    exc_req <= '{offset: off, status: s};
    @(posedge clk);
    exc_take <= 1'b0;
    #1 chk("saved", saved, sv);
    chk("state", state, ns);
    chk("vec_valid", {31'h0, vec_valid}, 32'h00000001);
    chk("vec_addr", vec_addr, {st[6] ? 12'hFFF : 12'h000, off});
    st = ns;
    @(posedge clk);
    #1 chk("vec_valid", {31'h0, vec_valid}, 32'h00000000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    logic [31:0] v;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    st = 32'h00000040;
    #1 chk("reset state", state, 32'h00000040);
    chk("reset saved", saved, 32'h00000000);
    // field decode for all-clear and all-set words; bit n sits at index 31-n
    for (int j = 0; j < 2; j++) begin
      v = (j == 0) ? 32'h00000000 : 32'hFFFFFFFF;
      wr(8'h00, v);
      chk("state", state, st);
      chk("low_power", {31'h0, low_pwr}, {31'h0, v[31-13]});
      chk("user_only", {31'h0, user_only}, {31'h0, v[31-17]});
      chk("fp_ok", {31'h0, fp_ok}, {31'h0, v[31-18]});
      chk("fetch_xlate", {31'h0, fetch_x}, {31'h0, v[31-26]});
      chk("data_xlate", {31'h0, data_x}, {31'h0, v[31-27]});
      chk("perf_mark", {31'h0, perf}, {31'h0, v[31-29]});
      chk("recoverable", {31'h0, recov}, {31'h0, v[31-30]});
      chk("little_endian", {31'h0, little}, {31'h0, v[31-31]});
      rd(8'h00, st, "state read");
    end
    // unmapped place: write ignored, read zero, read data gone next cycle
    wr(8'h40, 32'h12345678);
    rd(8'h40, 32'h00000000, "unmapped read");
    rd(8'h00, st, "state after unmapped");
    @(posedge clk);
    #1 chk("rdata idle", rdata, 32'h00000000);
    // interrupt gate
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, e ? 32'h00008000 : 32'h00000000);
      @(posedge clk);
      ev[0] <= 1'b1;
      ev[1] <= 1'b1;
      @(posedge clk);
      #1 chk("ext_take", {31'h0, ext_take}, e);
      chk("dec_take", {31'h0, dec_take}, e);
      ev[0] <= 1'b0;
      ev[1] <= 1'b0;
    end
    // floating point: each trap mode combination with the unit on
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 32'h00002000 | (k[0] ? 32'h00000800 : 0) | (k[1] ? 32'h00000100 : 0));
      fire(4);
      chk("fp_prog", {31'h0, fp_prog}, k != 0);
      chk("fp_precise", {31'h0, fp_prec}, k != 0);
      chk("fp_enable", {31'h0, fp_en}, k != 0);
      fire(3);
      chk("fp_unavail on", {31'h0, fp_unavail}, 32'h00000000);
    end
    wr(8'h00, 32'h00000900);
    fire(3);
    chk("fp_unavail off", {31'h0, fp_unavail}, 32'h00000001);
    fire(4);
    chk("fp_prog off", {31'h0, fp_prog}, 32'h00000000);
    // privilege
    for (int p = 0; p < 2; p++) begin
      wr(8'h00, p ? 32'h00004000 : 32'h00000000);
      fire(5);
      chk("priv_fault", {31'h0, priv_fault}, p);
    end
    // trace decisions
    wr(8'h00, 32'h00000400);
    tr('{is_branch: 1'b0, no_trace: 1'b0, faulted: 1'b0}, 1'b1, 1'b0);
    tr('{is_branch: 1'b0, no_trace: 1'b1, faulted: 1'b0}, 1'b0, 1'b0);
    tr('{is_branch: 1'b0, no_trace: 1'b0, faulted: 1'b1}, 1'b0, 1'b0);
    wr(8'h00, 32'h00000200);
    tr('{is_branch: 1'b1, no_trace: 1'b0, faulted: 1'b0}, 1'b1, 1'b1);
    tr('{is_branch: 1'b0, no_trace: 1'b0, faulted: 1'b0}, 1'b0, 1'b0);
    wr(8'h00, 32'h00000000);
    tr('{is_branch: 1'b1, no_trace: 1'b0, faulted: 1'b0}, 1'b0, 1'b0);
    // exception entry from a fully set word, then with high base off
    wr(8'h00, 32'hFFFFFFFF);
    exc(20'h00700, 10'h2A5);
    rd(8'h04, sv, "saved read");
    fire(0);
    chk("ext after entry", {31'h0, ext_take}, 32'h00000000);
    wr(8'h00, 32'h00000002);
    exc(20'h00300, 10'h000);
    chk("recoverable cleared", {31'h0, recov}, 32'h00000000);
    // return restores the saved fields
    @(posedge clk);
    rfi <= 1'b1;
    @(posedge clk);
    rfi <= 1'b0;
    #1 chk("state after return", state, (st & ~32'h87C0FF7F) | (sv & 32'h87C0FF7F));
    // machine check: taken with gate set, checkstop with it clear, sticky
    wr(8'h00, 32'h00001000);
    fire(2);
    chk("mchk_take", {31'h0, mchk_take}, 32'h00000001);
    chk("checkstop", {31'h0, checkstop}, 32'h00000000);
    wr(8'h00, 32'h00000000);
    fire(2);
    chk("mchk_take", {31'h0, mchk_take}, 32'h00000000);
    chk("checkstop", {31'h0, checkstop}, 32'h00000001);
    wr(8'h00, 32'h00001000);
    fire(2);
    chk("checkstop held", {31'h0, checkstop}, 32'h00000001);
    // status: two entries counted, checkstop flagged
    rd(8'h08, 32'h00000201, "status read");
    results();
  end
endmodule
